// ---- logic/bcs_map.vh ----
// Register map and field constants for the bridge control and status slice
`ifndef BCS_MAP_VH
`define BCS_MAP_VH
`define BCS_ADDR_RDCTL    8'h48
`define BCS_RD_START_BIT  1
`define BCS_ADDR_DATA0    8'h4B
`define BCS_ADDR_DATA1    8'h4C
`define BCS_ADDR_DATA2    8'h4D
`define BCS_ADDR_DATA3    8'h4E
`define BCS_ADDR_CTL      8'h4F
`define BCS_ADDR_STS      8'h50
`define BCS_DATA_RST      8'h00
`define BCS_CTL_SRC_BIT   4
`define BCS_CTL_EN_BIT    3
`define BCS_CTL_CLR_BIT   2
`define BCS_CTL_RLD_BIT   1
`define BCS_CTL_BLK_BIT   0
`define BCS_STS_PWR_BIT   7
`define BCS_STS_IRQ_BIT   6
`define BCS_STS_INIT_BIT  4
`define BCS_STS_REM_BIT   3
`define BCS_STS_CFG_BIT   2
`define BCS_STS_CCK_BIT   1
`define BCS_STS_ICK_BIT   0
`define BCS_CONFIG_CHECKSUM_OK_LEN 128
`define BCS_ID_CKSUM_LEN  256
`endif

// ---- logic/bcs_regs.v ----
// Bridge control, status and indirect data byte registers
`timescale 1ns/100ps
`default_nettype none
`include "bcs_map.vh"
module bcs_regs (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_b,
  // Register port
  input  wire       i_wr,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  // Pins and receiver status
  input  wire       i_mode_strap0,
  input  wire       i_sink_5v_pin,
  input  wire       i_rx_irq,
  // Indirect bus read
  output wire       o_bus_read_start,
  input  wire       i_bus_read_done,
  input  wire [31:0] i_bus_read_data,
  // Display-ID SRAM engine
  output wire       o_id_reload,
  output wire       o_id_clear,
  input  wire       i_id_done,
  input  wire       i_id_ck_ok,
  output wire       o_ddc_block,
  // Init progress
  input  wire       i_cfg_done,
  input  wire       i_cfg_ck_ok,
  input  wire       i_init_done,
  input  wire       i_rem_loaded,
  // Timebase control
  output wire       o_cec_source,
  output wire       o_cec_enable
);
  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  reg  [7:0] data_ff [0:3];
  reg  [7:0] nxt_data [0:3];
  reg        rd_start_ff;
  reg        nxt_rd_start;
  reg        cec_src_ff;
  reg        nxt_cec_src;
  reg        cec_en_ff;
  reg        nxt_cec_en;
  reg        clr_ff;
  reg        nxt_clr;
  reg        rld_ff;
  reg        nxt_rld;
  wire [3:0] wr_dat;
  wire       wr_ctl;
  wire       wr_rdctl;
  wire       rd_load;
  wire [7:0] ctl_view;
  wire [7:0] sts_view;
  wire       blk;
  wire       st_cfg;
  wire       st_cck;
  wire       st_init;
  wire       st_rem;
  wire       st_ick;
  integer    i;
  integer    j;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Address match
  function sel;
    input [7:0] a;
    input [7:0] b;
    sel = (a == b);
  endfunction

  // Byte k of a bus word
  function [7:0] word_byte;
    input [31:0] w;
    input [1:0]  k;
    word_byte = w[8*k +: 8];
  endfunction

  bcs_strap_cap u_strap (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_strap (i_mode_strap0),
    .o_value (blk)
  );

  bcs_seq u_seq (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_cfg_done   (i_cfg_done),
    .i_cfg_ck_ok  (i_cfg_ck_ok),
    .i_init_done  (i_init_done),
    .i_rem_loaded (i_rem_loaded),
    .i_id_ck_ok   (i_id_ck_ok),
    .i_id_done    (i_id_done),
    .o_cfg_done   (st_cfg),
    .o_cfg_ck     (st_cck),
    .o_init_done  (st_init),
    .o_rem_loaded (st_rem),
    .o_id_ck      (st_ick)
  );

  // --------------------------------------------------------------
  // Writes
  // --------------------------------------------------------------
  // data byte, control and read control write strobes, and read load
  assign wr_dat[0] = i_wr && sel(i_addr, `BCS_ADDR_DATA0);
  assign wr_dat[1] = i_wr && sel(i_addr, `BCS_ADDR_DATA1);
  assign wr_dat[2] = i_wr && sel(i_addr, `BCS_ADDR_DATA2);
  assign wr_dat[3] = i_wr && sel(i_addr, `BCS_ADDR_DATA3);
  assign wr_ctl    = i_wr && sel(i_addr, `BCS_ADDR_CTL);
  assign wr_rdctl  = i_wr && sel(i_addr, `BCS_ADDR_RDCTL);
  assign rd_load   = rd_start_ff && i_bus_read_done;

  // --------------------------------------------------------------
  // Data byte next state
  // --------------------------------------------------------------
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      nxt_data[j] = data_ff[j];
      if (wr_dat[j])
        nxt_data[j] = i_wdata;
      if (rd_load)
        nxt_data[j] = word_byte(i_bus_read_data, j[1:0]);
    end
  end

  // --------------------------------------------------------------
  // Read start next state
  // --------------------------------------------------------------
  always @* begin
    nxt_rd_start = rd_start_ff;
    if (rd_load)
      nxt_rd_start = 1'b0;
    if (wr_rdctl)
      nxt_rd_start = i_wdata[`BCS_RD_START_BIT];
  end

  // --------------------------------------------------------------
  // Control next state
  // --------------------------------------------------------------
  always @* begin
    nxt_cec_src = cec_src_ff;
    nxt_cec_en  = cec_en_ff;
    nxt_clr     = clr_ff;
    nxt_rld     = rld_ff;
    if (wr_ctl) begin
      nxt_cec_src = i_wdata[`BCS_CTL_SRC_BIT];
      nxt_cec_en  = i_wdata[`BCS_CTL_EN_BIT];
      nxt_clr     = i_wdata[`BCS_CTL_CLR_BIT] & i_wdata[`BCS_CTL_RLD_BIT];
      nxt_rld     = i_wdata[`BCS_CTL_RLD_BIT];
    end else if (i_id_done) begin
      nxt_rld = 1'b0;
      nxt_clr = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Data byte registers
  // --------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      for (i = 0; i < 4; i = i + 1)
        data_ff[i] <= `BCS_DATA_RST;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        data_ff[i] <= nxt_data[i];
    end
  end

  // --------------------------------------------------------------
  // Read start register
  // --------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      rd_start_ff <= 1'b0;
    end else begin
      rd_start_ff <= nxt_rd_start;
    end
  end

  // --------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      cec_src_ff  <= 1'b0;
      cec_en_ff   <= 1'b0;
      clr_ff      <= 1'b0;
      rld_ff      <= 1'b0;
    end else begin
      cec_src_ff  <= nxt_cec_src;
      cec_en_ff   <= nxt_cec_en;
      clr_ff      <= nxt_clr;
      rld_ff      <= nxt_rld;
    end
  end

  // --------------------------------------------------------------
  // Read views
  // --------------------------------------------------------------
  // reserved control bits zero
  assign ctl_view[7:5]              = 3'h0;
  assign ctl_view[`BCS_CTL_SRC_BIT] = cec_src_ff;
  assign ctl_view[`BCS_CTL_EN_BIT]  = cec_en_ff;
  assign ctl_view[`BCS_CTL_CLR_BIT] = clr_ff;
  assign ctl_view[`BCS_CTL_RLD_BIT] = rld_ff;
  assign ctl_view[`BCS_CTL_BLK_BIT] = blk;
  assign sts_view[`BCS_STS_PWR_BIT]  = i_sink_5v_pin;
  assign sts_view[`BCS_STS_IRQ_BIT]  = i_rx_irq;
  assign sts_view[5]                 = 1'b0;
  assign sts_view[`BCS_STS_INIT_BIT] = st_init;
  assign sts_view[`BCS_STS_REM_BIT]  = st_rem;
  assign sts_view[`BCS_STS_CFG_BIT]  = st_cfg;
  assign sts_view[`BCS_STS_CCK_BIT]  = st_cck;
  assign sts_view[`BCS_STS_ICK_BIT]  = st_ick;

  // --------------------------------------------------------------
  // Reads
  // --------------------------------------------------------------
  always @* begin
    o_rdata = 8'h00;
    case (i_addr)
      `BCS_ADDR_DATA0: o_rdata = data_ff[0];
      `BCS_ADDR_DATA1: o_rdata = data_ff[1];
      `BCS_ADDR_DATA2: o_rdata = data_ff[2];
      `BCS_ADDR_DATA3: o_rdata = data_ff[3];
      `BCS_ADDR_CTL:   o_rdata = ctl_view;
      `BCS_ADDR_STS:   o_rdata = sts_view;
      default:         o_rdata = 8'h00;
    endcase
  end

  assign o_bus_read_start = rd_start_ff;
  assign o_id_reload      = rld_ff;
  assign o_id_clear       = clr_ff & rld_ff;
  assign o_ddc_block      = blk;
  assign o_cec_source     = cec_src_ff;
  assign o_cec_enable     = cec_en_ff;
endmodule // bcs_regs
`default_nettype wire

// ---- logic/bcs_seq.v ----
// Initialization progress tracker
`timescale 1ns/100ps
`default_nettype none
module bcs_seq (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_b,
  // Progress events
  input  wire i_cfg_done,
  input  wire i_cfg_ck_ok,
  input  wire i_init_done,
  input  wire i_rem_loaded,
  input  wire i_id_ck_ok,
  input  wire i_id_done,
  // Status flags
  output reg  o_cfg_done,
  output reg  o_cfg_ck,
  output reg  o_init_done,
  output reg  o_rem_loaded,
  output reg  o_id_ck
);
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_cfg_done   <= 1'b0;
      o_cfg_ck     <= 1'b0;
      o_init_done  <= 1'b0;
      o_rem_loaded <= 1'b0;
      o_id_ck      <= 1'b0;
    end else begin
      if (i_cfg_done) begin
        o_cfg_done <= 1'b1;
        o_cfg_ck   <= i_cfg_ck_ok;
      end
      if (i_init_done && (o_cfg_done || i_cfg_done))
        o_init_done <= 1'b1;
      if (i_rem_loaded)
        o_rem_loaded <= 1'b1;
      if (i_id_done)
        o_id_ck <= i_id_ck_ok;
    end
  end
endmodule // bcs_seq
`default_nettype wire

// ---- logic/bcs_strap_cap.v ----
// Strap capture after reset release
`timescale 1ns/100ps
`default_nettype none
module bcs_strap_cap (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_b,
  // Strap in and held value
  input  wire i_strap,
  output reg  o_value
);
  reg done_ff;
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      done_ff <= 1'b0;
      o_value <= 1'b0;
    end else if (!done_ff) begin
      done_ff <= 1'b1;
      o_value <= i_strap;
    end
  end
endmodule // bcs_strap_cap
`default_nettype wire

// ---- testbench/bcs_far_model.sv ----
// Reload and indirect read engine model
`timescale 1ns/100ps
`default_nettype none
module bcs_far_model #(parameter int LAT = 3) (
  input wire logic         i_clk, i_reload, i_rd,
  input wire logic  [31:0] i_word,
  output var logic         o_id_done = 1'b0,
  output var logic         o_rd_done = 1'b0,
  output var logic  [31:0] o_data = 32'h0
);
  int n = 0;
  always @(posedge i_clk) begin
    o_id_done <= 1'b0;
    o_rd_done <= 1'b0;
    o_data <= ~o_data;
    n <= (i_reload || i_rd) ? n + 1 : 0;
    if (n == LAT) begin
      o_id_done <= i_reload;
      o_rd_done <= i_rd;
      o_data <= i_word;
      n <= 0;
    end
  end
endmodule // bcs_far_model
`default_nettype wire

// ---- testbench/bcs_regs_assertions.sv ----
// Assertion checker for the bridge register slice
`timescale 1ns/100ps
`default_nettype none
module bcs_regs_chk (
  input wire logic        i_clk, i_rst_b, i_wr, i_mode_strap0, i_sink_5v_pin, i_rx_irq,
  input wire logic        i_bus_read_done, i_id_done, i_id_ck_ok, i_cfg_done, i_cfg_ck_ok,
  input wire logic        i_init_done, i_rem_loaded, o_bus_read_start, o_id_reload, o_id_clear,
  input wire logic        o_ddc_block, o_cec_source, o_cec_enable,
  input wire logic [7:0]  i_addr, i_wdata, o_rdata,
  input wire logic [31:0] i_bus_read_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_ctl_wr; i_wr && i_addr == 8'h4F; endsequence
  sequence s_sts_rd; i_addr == 8'h50; endsequence
  chk_power_bit: assert property (s_sts_rd |-> o_rdata[7] == i_sink_5v_pin)
    else $error("power bit wrong");
  chk_irq_bit: assert property (s_sts_rd |-> o_rdata[6] == i_rx_irq)
    else $error("irq bit wrong");
  chk_rsvd_zero: assert property ((s_sts_rd |-> !o_rdata[5]) and (i_addr == 8'h4F |-> o_rdata[7:5] == 3'h0))
    else $error("reserved bit set");
  chk_init_order: assert property ((s_sts_rd and o_rdata[4]) |-> o_rdata[2])
    else $error("init before config");
  chk_reload_set: assert property ((s_ctl_wr and (i_wdata[1] && !i_id_done)) |=> o_id_reload)
    else $error("reload not started");
  chk_reload_end: assert property (o_id_reload && i_id_done && !i_wr |=> !o_id_reload && !o_id_clear)
    else $error("reload not cleared");
  chk_clear_pair: assert property ((s_ctl_wr and (i_wdata[2] && !i_wdata[1])) |=> !o_id_clear)
    else $error("clear without reload");
  chk_ddc_fixed: assert property (s_ctl_wr |=> $stable(o_ddc_block))
    else $error("strap bit written");
  chk_timebase_wr: assert property (s_ctl_wr |=> {o_cec_source, o_cec_enable} == $past(i_wdata[4:3]))
    else $error("timebase bits wrong");
  chk_read_clear: assert property (o_bus_read_start && i_bus_read_done && !i_wr |=> !o_bus_read_start)
    else $error("read start stuck");
endmodule // bcs_regs_chk
bind bcs_regs bcs_regs_chk u_chk (.*);
`default_nettype wire

// ---- testbench/tb_bridge_control_status_regs.sv ----
// Self-checking bench for the bridge register slice
`timescale 1ns/100ps
`default_nettype none
module tb_bridge_control_status_regs;
  logic        i_clk = 0, i_rst_b = 0, i_wr = 0, rd_v = 0, strap = 1, ck = 1, brs, bdone, rld, idd;
  logic [1:0]  pin = 2'h0;
  logic [3:0]  ev = 4'h0;
  logic        clr, ddc, src, en;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata, exp_v, q[$];
  logic [15:0] r = 16'h1B3F;
  logic [31:0] word = 32'h0, bdata;
  int          errors = 0, checked = 0, cyc = 0;
  bcs_regs DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_mode_strap0(strap), .i_sink_5v_pin(pin[1]), .i_rx_irq(pin[0]),
    .o_bus_read_start(brs), .i_bus_read_done(bdone), .i_bus_read_data(bdata), .o_id_reload(rld),
    .o_id_clear(clr), .i_id_done(idd), .i_id_ck_ok(ck), .o_ddc_block(ddc), .i_cfg_done(ev[3]),
    .i_cfg_ck_ok(ev[2]), .i_init_done(ev[1]), .i_rem_loaded(ev[0]), .o_cec_source(src), .o_cec_enable(en));
  bcs_far_model #(.LAT(3)) u_far (.i_clk(i_clk), .i_reload(rld), .i_rd(brs), .i_word(word),
    .o_id_done(idd), .o_rd_done(bdone), .o_data(bdata));
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic finish_test;
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge i_clk);
    i_addr <= a;
    rd_v <= 1;
    q.push_back(e);
    @(posedge i_clk);
    rd_v <= 0;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge i_clk);
    ev <= v;
    @(posedge i_clk);
    ev <= 4'h0;
  endtask
  task automatic cmp(input logic [7:0] e);
    checked++;
    if (e !== o_rdata) begin
      errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, o_rdata);
    end
  endtask
  task automatic cmp_pins(input logic [4:0] e);
    checked++;
    if (e !== {src, en, clr, rld, ddc}) begin
      errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, {src, en, clr, rld, ddc});
    end
  endtask
  initial forever #4 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    if (rd_v) begin
      exp_v = q.pop_front();
      cmp(exp_v);
      if (i_addr == 8'h4F) cmp_pins(exp_v[4:0]);
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1;
    rd(8'h4D, 8'h00);
    rd(8'h4F, 8'h01);
    pin <= 2'h2;
    rd(8'h50, 8'h80);
    pin <= 2'h1;
    rd(8'h50, 8'h40);
    repeat (4) begin
      r = nx(r);
      wr(8'h4D, r[7:0]);
      wr(8'h4E, r[15:8]);
      rd(8'h4D, r[7:0]);
      rd(8'h4E, r[15:8]);
    end
    strap <= 0;
    wr(8'h4F, 8'hFE);
    rd(8'h4F, 8'h1F);
    repeat (8) @(posedge i_clk);
    rd(8'h4F, 8'h19);
    wr(8'h4F, 8'h04);
    rd(8'h4F, 8'h01);
    word <= {nx(r), r};
    wr(8'h48, 8'h02);
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 4; i++) rd(8'h4B + i[7:0], word[8*i +: 8]);
    pulse(4'h2);
    rd(8'h50, 8'h41);
    pulse(4'hC);
    pulse(4'h1);
    pulse(4'h2);
    rd(8'h50, 8'h5F);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h5F);
    rd(8'h60, 8'h00);
    finish_test;
  end
endmodule // tb_bridge_control_status_regs
`default_nettype wire
